// >>> core/spi_tx_pkg.sv
// Purpose: Shared constants and types of the serial slave transmit block.
// Assumes: A 12-bit register address and byte-wide transmit memory.
// Notes:   The legacy register names share the offsets of the current ones.
package spi_tx_pkg;

  localparam int            REG_AW        = 12;
  localparam int            DATA_W        = 32;
  localparam int            BYTE_W        = 8;
  localparam int            CNT_W         = 10;
  localparam int            LIST_W        = 2;

  // Legacy and current names decode to the same offsets.
  localparam logic [11:0]   OFF_TX_START  = 12'h544;
  localparam logic [11:0]   OFF_TX_MAX    = 12'h548;
  localparam logic [11:0]   OFF_TX_SENT   = 12'h54c;
  localparam logic [11:0]   OFF_TX_LIST   = 12'h550;
  localparam logic [11:0]   OFF_LINK_FMT  = 12'h554;
  localparam logic [11:0]   OFF_IGN_FILL  = 12'h55c;
  localparam logic [11:0]   OFF_ORC_FILL  = 12'h5c0;

  localparam logic [9:0]    CNT_MAX       = 10'h3ff;
  localparam logic [31:0]   RST_WORD      = 32'h0000_0000;
  localparam logic [7:0]    RST_BYTE      = 8'h00;
  localparam logic [2:0]    LAST_BIT      = 3'h7;
  localparam logic [10:0]   IDX_TOP       = 11'h7ff;

  // Bit 0 is the bit order, bit 1 the clock phase, bit 2 the clock polarity.
  typedef struct packed {
    logic clock_polarity_select;
    logic clock_phase_select;
    logic low_bit_first;
  } link_fmt_t;

  localparam link_fmt_t     FMT_RESET     = '0;

  typedef struct packed {
    logic csn;
    logic sck;
  } spi_pins_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b11
  } tx_state_t;

  typedef enum logic [1:0] {
    SRC_MEM = 2'b00,
    SRC_IGN = 2'b01,
    SRC_ORC = 2'b10
  } byte_src_t;

endpackage

// >>> core/pin_sync.sv
// Purpose: Two-flop synchroniser with edge pulses for slow pin inputs.
// Assumes: Pins change far slower than clk_i.
// Notes:   Edges are found on the second stage only.
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W       = 2,
  parameter logic [1:0] RST_VAL = 2'b10
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;

  generate
    if (W != 2)
    begin : g_bad_width
      $error("pin_sync serves exactly two pins");
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= RST_VAL;
      sync <= RST_VAL;
      prev <= RST_VAL;
    end
    else
    begin
      meta <= pin_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o  = sync & ~prev;
  assign fall_o  = ~sync & prev;

endmodule // pin_sync

// >>> core/byte_shift.sv
// Purpose: Byte shifter that presents one bit at a time in either order.
// Assumes: Load and shift never come in the same cycle.
// Notes:   Load wins if they do.
`timescale 1ns/1ps
module byte_shift #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic         shift_i,
  input  wire logic         low_first_i,
  input  wire logic [W-1:0] din_i,
  output logic              bit_o
);

  logic [W-1:0] sh;

  generate
    if (W < 2)
    begin : g_bad_width
      $error("byte_shift needs at least two bits");
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sh <= '0;
    else if (load_i)
      sh <= din_i;
    else if (shift_i)
      sh <= low_first_i ? (sh >> 1) : (sh << 1);
  end

  assign bit_o = low_first_i ? sh[0] : sh[W-1];

endmodule // byte_shift

// >>> core/spi_tx_core.sv
// What this block does
// RULE_01 - Hold a transmit maximum byte count from zero to 0x3FF.
// RULE_02 - Record bytes sent after each granted transaction; count is read-only.
// RULE_03 - Order setting 0 shifts high bit first, 1 shifts low bit first.
// RULE_04 - Phase 0: sample on leading clock edge, change data on trailing edge.
// RULE_05 - Phase 1: sample on trailing clock edge, change data on leading edge.
// RULE_06 - Polarity 0 means clock idles low; 1 means clock idles high.
// RULE_07 - Ungranted transactions send the ignored-transaction fill character for every byte.
// RULE_08 - Bytes beyond the maximum count send the over-read fill character.
// RULE_09 - Configuration, count and fill registers reset to zero.
// RULE_10 - Fetch bytes from memory in sequence from the buffer start address.
// RULE_11 - Legacy pointer, maximum and sent-count names alias the same storage.
//
// Purpose: Transmit side and link format of a serial peripheral slave.
// Assumes: Memory answers a read in the cycle after mem_rd_o; grant is on clk_i.
// Notes:   Serial pins are sampled by clk_i, so the serial clock must be slow.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module spi_tx_core
  import spi_tx_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire spi_tx_pkg::reg_req_t  reg_i,
  output logic [31:0]                rd_data_o,
  input  wire spi_tx_pkg::spi_pins_t spi_i,
  output logic                       miso_o,
  output logic                       miso_oe_o,
  input  wire logic                  granted_i,
  output logic [ADDR_W-1:0]          mem_addr_o,
  output logic                       mem_rd_o,
  input  wire logic [7:0]            mem_rdata_i,
  output logic                       txn_end_o
);

  generate
    if (ADDR_W != DATA_W)
    begin : g_bad_addr
      $error("memory address must be as wide as the pointer register");
    end
  endgenerate

  logic [31:0]       tx_start;
  logic [CNT_W-1:0]  tx_max;
  logic [CNT_W-1:0]  tx_sent;
  logic [LIST_W-1:0] tx_list;
  link_fmt_t         fmt;
  logic [7:0]        ign_fill;
  logic [7:0]        orc_fill;

  tx_state_t         state;
  logic              frame_granted;
  logic [10:0]       fidx;
  logic [10:0]       done_cnt;
  logic [2:0]        bit_cnt;
  logic [2:0]        samp_cnt;
  logic              started;
  logic              cap1;
  logic              cap2;
  byte_src_t         src1;
  byte_src_t         src2;
  logic [7:0]        pend_byte;
  logic              pend_valid;

  spi_pins_t         lvl;
  spi_pins_t         rise;
  spi_pins_t         fall;
  logic              lead_ev;
  logic              trail_ev;
  logic              sample_ev;
  logic              shift_ev;
  logic              advance;
  logic              frame_end;
  logic              fetch_go;
  logic [10:0]       fetch_idx;
  logic              fetch_grant;
  byte_src_t         fetch_src;
  logic              sh_load;
  logic              sh_shift;
  logic              sh_bit;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  function automatic byte_src_t pick_src(input logic g, input logic [10:0] idx,
                                         input logic [CNT_W-1:0] lim);
    if (!g)
      pick_src = SRC_IGN;
    else if (idx >= {1'b0, lim})
      pick_src = SRC_ORC;
    else
      pick_src = SRC_MEM;
  endfunction

  pin_sync #(
    .W       (2),
    .RST_VAL (2'b10)
  ) u_pins (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (spi_i),
    .level_o (lvl),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  // RULE_06 polarity picks edges
  assign lead_ev   = fmt.clock_polarity_select ? fall.sck : rise.sck;
  assign trail_ev  = fmt.clock_polarity_select ? rise.sck : fall.sck;
  // RULE_04 phase zero edges
  // RULE_05 phase one edges
  assign sample_ev = fmt.clock_phase_select ? trail_ev : lead_ev;
  assign shift_ev  = fmt.clock_phase_select ? lead_ev : trail_ev;
  // With phase 1 the first leading edge only presents the already loaded bit.
  assign advance   = (state == ST_RUN) && shift_ev
                     && (started || !fmt.clock_phase_select);
  assign frame_end = (state != ST_IDLE) && rise.csn;

  assign sh_load   = ((state == ST_LOAD) && pend_valid && !frame_end)
                     || (advance && (bit_cnt == LAST_BIT) && !frame_end);
  assign sh_shift  = advance && (bit_cnt != LAST_BIT);
  assign fetch_go  = ((state == ST_IDLE) && fall.csn) || sh_load;
  assign fetch_idx = (state == ST_IDLE) ? '0 : fidx;
  assign fetch_grant = (state == ST_IDLE) ? granted_i : frame_granted;
  // RULE_07 fill when ignored
  // RULE_08 fill past maximum
  assign fetch_src = pick_src(fetch_grant, fetch_idx, tx_max);

  byte_shift #(
    .W           (BYTE_W)
  ) u_shift (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .load_i      (sh_load),
    .shift_i     (sh_shift),
    // RULE_03 bit order select
    .low_first_i (fmt.low_bit_first),
    .din_i       (pend_byte),
    .bit_o       (sh_bit)
  );

  // RULE_09 zero after reset
  // RULE_11 shared alias storage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_start <= RST_WORD;
      tx_max   <= '0;
      tx_list  <= '0;
      fmt      <= FMT_RESET;
      ign_fill <= RST_BYTE;
      orc_fill <= RST_BYTE;
    end
    else if (reg_i.wr)
    begin
      if (hit(reg_i.addr, OFF_TX_START))
        tx_start <= reg_i.wdata;
      // RULE_01 ten-bit maximum count
      if (hit(reg_i.addr, OFF_TX_MAX))
        tx_max <= reg_i.wdata[CNT_W-1:0];
      if (hit(reg_i.addr, OFF_TX_LIST))
        tx_list <= reg_i.wdata[LIST_W-1:0];
      if (hit(reg_i.addr, OFF_LINK_FMT))
        fmt <= reg_i.wdata[2:0];
      if (hit(reg_i.addr, OFF_IGN_FILL))
        ign_fill <= reg_i.wdata[7:0];
      if (hit(reg_i.addr, OFF_ORC_FILL))
        orc_fill <= reg_i.wdata[7:0];
    end
  end

  // Read data stands for one cycle only; unmapped offsets read as zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_data_o <= RST_WORD;
    else if (!reg_i.rd)
      rd_data_o <= RST_WORD;
    else if (hit(reg_i.addr, OFF_TX_START))
      rd_data_o <= tx_start;
    else if (hit(reg_i.addr, OFF_TX_MAX))
      rd_data_o <= {22'h0, tx_max};
    else if (hit(reg_i.addr, OFF_TX_SENT))
      rd_data_o <= {22'h0, tx_sent};
    else if (hit(reg_i.addr, OFF_TX_LIST))
      rd_data_o <= {30'h0, tx_list};
    else if (hit(reg_i.addr, OFF_LINK_FMT))
      rd_data_o <= {29'h0, fmt};
    else if (hit(reg_i.addr, OFF_IGN_FILL))
      rd_data_o <= {24'h0, ign_fill};
    else if (hit(reg_i.addr, OFF_ORC_FILL))
      rd_data_o <= {24'h0, orc_fill};
    else
      rd_data_o <= RST_WORD;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state         <= ST_IDLE;
      frame_granted <= 1'b0;
      started       <= 1'b0;
      bit_cnt       <= '0;
    end
    else if (frame_end)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (fall.csn)
          begin
            state         <= ST_LOAD;
            frame_granted <= granted_i;
            started       <= 1'b0;
            bit_cnt       <= '0;
          end
        end
        ST_LOAD:
        begin
          if (pend_valid)
            state <= ST_RUN;
        end
        ST_RUN:
        begin
          if (shift_ev)
            started <= 1'b1;
          if (advance)
            bit_cnt <= bit_cnt + 3'h1;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Fetch pipeline: request, memory answers, byte lands in the pending slot.
  // A fill character takes the same path so every byte has the same latency.
  // RULE_10 sequential buffer fetch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem_rd_o   <= 1'b0;
      mem_addr_o <= '0;
      fidx       <= '0;
      cap1       <= 1'b0;
      cap2       <= 1'b0;
      src1       <= SRC_MEM;
      src2       <= SRC_MEM;
    end
    else
    begin
      mem_rd_o <= fetch_go && (fetch_src == SRC_MEM);
      cap1     <= fetch_go;
      src1     <= fetch_src;
      cap2     <= cap1;
      src2     <= src1;
      if (fetch_go)
      begin
        mem_addr_o <= tx_start + {21'h0, fetch_idx};
        if (fetch_idx != IDX_TOP)
          fidx <= fetch_idx + 11'h1;
        else
          fidx <= fetch_idx;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_byte  <= RST_BYTE;
      pend_valid <= 1'b0;
    end
    else if (cap2)
    begin
      pend_valid <= 1'b1;
      case (src2)
        SRC_MEM: pend_byte <= mem_rdata_i;
        SRC_IGN: pend_byte <= ign_fill;
        SRC_ORC: pend_byte <= orc_fill;
        default: pend_byte <= orc_fill;
      endcase
    end
    else if (sh_load || (state == ST_IDLE))
      pend_valid <= 1'b0;
  end

  // A byte counts as sent once its eighth bit has been sampled by the master.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      samp_cnt <= '0;
      done_cnt <= '0;
    end
    else if ((state == ST_IDLE) && fall.csn)
    begin
      samp_cnt <= '0;
      done_cnt <= '0;
    end
    else if ((state == ST_RUN) && sample_ev)
    begin
      samp_cnt <= samp_cnt + 3'h1;
      if ((samp_cnt == LAST_BIT) && (done_cnt != IDX_TOP))
        done_cnt <= done_cnt + 11'h1;
    end
  end

  // RULE_02 sent count update
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_sent   <= '0;
      txn_end_o <= 1'b0;
    end
    else
    begin
      txn_end_o <= frame_end && frame_granted;
      if (frame_end && frame_granted)
        tx_sent <= (done_cnt > {1'b0, tx_max}) ? tx_max : done_cnt[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end
    else
    begin
      miso_o    <= (state == ST_RUN) ? sh_bit : 1'b0;
      miso_oe_o <= (state != ST_IDLE);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_max_store: assert property ( // RULE_01
    (reg_i.wr && hit(reg_i.addr, OFF_TX_MAX)) ##1 !reg_i.wr
    ##1 (reg_i.rd && hit(reg_i.addr, OFF_TX_MAX))
    |=> rd_data_o == {22'h0, $past(reg_i.wdata[CNT_W-1:0], 3)})
    else $error("maximum count did not read back");

  a_sent_ro: assert property ( // RULE_02
    (reg_i.wr && hit(reg_i.addr, OFF_TX_SENT) && !(frame_end && frame_granted))
    |=> $stable(tx_sent))
    else $error("write changed the sent count");

  a_sent_bound: assert property ( // RULE_02
    txn_end_o |-> tx_sent <= tx_max)
    else $error("sent count above maximum");

  a_order_msb: assert property ( // RULE_03
    sh_load && !fmt.low_bit_first ##1 !sh_load && !sh_shift && $stable(fmt)
    |-> sh_bit == $past(pend_byte[BYTE_W-1]))
    else $error("first bit not the high bit");

  a_order_lsb: assert property ( // RULE_03
    sh_load && fmt.low_bit_first ##1 !sh_load && !sh_shift && $stable(fmt)
    |-> sh_bit == $past(pend_byte[0]))
    else $error("first bit not the low bit");

  a_phase_zero: assert property ( // RULE_04
    !fmt.clock_phase_select && sh_shift |-> trail_ev && !lead_ev)
    else $error("phase 0 shifted off the trailing edge");

  a_phase_one: assert property ( // RULE_05
    fmt.clock_phase_select && sh_shift |-> lead_ev && !trail_ev)
    else $error("phase 1 shifted off the leading edge");

  a_polarity: assert property ( // RULE_06
    lead_ev |-> lvl.sck == !fmt.clock_polarity_select)
    else $error("leading edge left the wrong level");

  a_ignored_fill: assert property ( // RULE_07
    cap2 && (state != ST_IDLE) && !frame_granted |=> pend_byte == $past(ign_fill))
    else $error("ignored transaction sent a buffer byte");

  a_overread_fill: assert property ( // RULE_08
    fetch_go && fetch_grant && (fetch_idx >= {1'b0, tx_max})
    |=> ##1 src2 == SRC_ORC)
    else $error("over-read byte not marked for fill");

  a_reset_zero: assert property ( // RULE_09
    $past(rst_i) |-> (fmt == FMT_RESET) && (tx_max == '0) && (tx_sent == '0)
                     && (ign_fill == RST_BYTE) && (orc_fill == RST_BYTE))
    else $error("register not zero after reset");

  a_fetch_addr: assert property ( // RULE_10
    mem_rd_o |-> mem_addr_o == tx_start + {21'h0, $past(fetch_idx)})
    else $error("fetch address out of sequence");

  a_alias_start: assert property ( // RULE_11
    (reg_i.wr && hit(reg_i.addr, OFF_TX_START)) ##1 !reg_i.wr
    ##1 (reg_i.rd && hit(reg_i.addr, OFF_TX_START))
    |=> rd_data_o == $past(reg_i.wdata, 3))
    else $error("start address did not read back");

endmodule // spi_tx_core

// >>> verification/spi_master_model.sv
// Purpose: Behavioural serial master that frames bytes and collects the slave's data.
// Assumes: Half period of 200 ns on the serial clock, asynchronous to clk_i.
// Notes:   Data is read late in each bit, because the slave answers a few clocks late.
`timescale 1ns/1ps
module spi_master_model
  import spi_tx_pkg::*;
(
  output spi_tx_pkg::spi_pins_t pins_o,
  input  wire logic             miso_i
);
  import spi_tx_pkg::*;

  logic [7:0] rx_q[$];

  initial pins_o = '{csn: 1'b1, sck: 1'b0};

  task automatic frame(input int nbits, input logic pol, input logic pha);
    logic [7:0] sh;
    sh = 8'h00;
    rx_q.delete();
    // idle level.
    // The clock stands at its idle level while no frame is open.
    pins_o.sck = pol;
    #213;
    pins_o.csn = 1'b0;
    #600;
    for (int i = 0; i < nbits; i++)
    begin
      pins_o.sck = ~pol;
      #200;
      if (!pha)
        sh = {sh[6:0], miso_i};
      pins_o.sck = pol;
      #200;
      if (pha)
        sh = {sh[6:0], miso_i};
      if (i % 8 == 7)
        rx_q.push_back(sh);
    end
    pins_o.csn = 1'b1;
  endtask
endmodule // spi_master_model

// >>> verification/spi_tx_core_tb.sv
// Purpose: Self-checking bench of the serial slave transmit block.
// Assumes: Memory answers in the cycle after each read pulse.
// Notes:   Serial traffic comes from the master model in its own file.
`timescale 1ns/1ps
module spi_tx_core_tb;
  import spi_tx_pkg::*;

  logic        clk_i       = 1'b0;
  logic        rst_i       = 1'b1;
  reg_req_t    reg_i       = '0;
  logic [31:0] rd_data_o;
  spi_pins_t   spi_i;
  logic        miso_o;
  logic        miso_oe_o;
  logic        granted_i   = 1'b0;
  logic [31:0] mem_addr_o;
  logic        mem_rd_o;
  logic [7:0]  mem_rdata_i = 8'h00;
  logic        txn_end_o;
  logic        miso_last   = 1'b0;
  logic        miso_w;
  logic [31:0] addr_q[$];
  int          n_end       = 0;
  int          n_oe        = 0;
  int          n_fail      = 0;
  int          compares    = 0;

  always #25 clk_i = ~clk_i;

  // A released line shows the inverse of its last value, never a held copy.
  assign miso_w = miso_oe_o ? miso_o : ~miso_last;

  function automatic logic [7:0] memval(input logic [31:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      rev8[i] = b[7-i];
  endfunction

  always @(posedge clk_i)
  begin
    miso_last   <= miso_oe_o ? miso_o : miso_last;
    mem_rdata_i <= (mem_rd_o === 1'b1) ? memval(mem_addr_o) : ~mem_rdata_i;
    if (mem_rd_o === 1'b1)
      addr_q.push_back(mem_addr_o);
    if (txn_end_o === 1'b1)
      n_end <= n_end + 1;
    if (miso_oe_o === 1'b1)
      n_oe <= n_oe + 1;
  end

  spi_tx_core #(.ADDR_W(32)) spi_tx_core_i (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .reg_i       (reg_i),
    .rd_data_o   (rd_data_o),
    .spi_i       (spi_i),
    .miso_o      (miso_o),
    .miso_oe_o   (miso_oe_o),
    .granted_i   (granted_i),
    .mem_addr_o  (mem_addr_o),
    .mem_rd_o    (mem_rd_o),
    .mem_rdata_i (mem_rdata_i),
    .txn_end_o   (txn_end_o)
  );

  spi_master_model spi_master_model_i (
    .pins_o (spi_i),
    .miso_i (miso_w)
  );

  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    reg_i.wr <= 1'b0;
  endtask

  task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_i);
    reg_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    reg_i.rd <= 1'b0;
    #1;
    check(rd_data_o, exp, what);
  endtask

  task automatic wait_end(input int target);
    for (int i = 0; i < 40 && n_end != target; i++)
      @(posedge clk_i);
    if (n_end != target)
    begin
      n_fail++;
      $display("mismatch at %0t: no end-of-frame pulse", $time);
      final_report();
    end
  endtask

  task automatic t_reset();
    reg_chk(OFF_TX_START, 32'h0000_0000, "start");
    reg_chk(OFF_TX_MAX, 32'h0000_0000, "max");
    reg_chk(OFF_TX_SENT, 32'h0000_0000, "sent");
    reg_chk(OFF_LINK_FMT, 32'h0000_0000, "fmt");
    reg_chk(OFF_IGN_FILL, 32'h0000_0000, "ignfill");
    reg_chk(OFF_ORC_FILL, 32'h0000_0000, "orcfill");
    reg_chk(12'h600, 32'h0000_0000, "unmapped");
    check(32'({miso_oe_o, miso_o}), 32'h0, "idle pins");
    $display("test reset done");
  endtask

  task automatic t_regs();
    reg_wr(OFF_TX_MAX, 32'hffff_ffff);
    reg_chk(OFF_TX_MAX, 32'h0000_03ff, "max top");
    reg_wr(OFF_TX_MAX, 32'h0000_0000);
    reg_chk(OFF_TX_MAX, 32'h0000_0000, "max zero");
    reg_wr(OFF_TX_SENT, 32'h0000_0012);
    reg_chk(OFF_TX_SENT, 32'h0000_0000, "sent ro");
    reg_wr(OFF_TX_START, 32'hdead_beef);
    reg_chk(OFF_TX_START, 32'hdead_beef, "start");
    reg_wr(OFF_LINK_FMT, 32'hffff_ffff);
    reg_chk(OFF_LINK_FMT, 32'h0000_0007, "fmt");
    reg_wr(OFF_TX_LIST, 32'h0000_0003);
    reg_chk(OFF_TX_LIST, 32'h0000_0003, "list");
    reg_wr(OFF_IGN_FILL, 32'h0000_01ff);
    reg_chk(OFF_IGN_FILL, 32'h0000_00ff, "ignfill");
    reg_wr(12'h600, 32'h1234_5678);
    reg_chk(12'h600, 32'h0000_0000, "unmapped");
    $display("test registers done");
  endtask

  // Every order, phase and polarity, with limits from zero to three bytes.
  task automatic t_modes();
    logic [31:0] st;
    logic [31:0] mx;
    logic [7:0]  e;
    int          tgt;
    reg_wr(OFF_ORC_FILL, 32'h0000_00c3);
    granted_i <= 1'b1;
    for (int m = 0; m < 8; m++)
    begin
      st = 32'h0000_0100 + 32'(m * 17);
      mx = 32'(m % 4);
      reg_wr(OFF_LINK_FMT, 32'(m));
      reg_wr(OFF_TX_START, st);
      reg_wr(OFF_TX_MAX, mx);
      addr_q.delete();
      tgt = n_end + 1;
      spi_master_model_i.frame(32, m[2], m[1]);
      wait_end(tgt);
      check(32'(spi_master_model_i.rx_q.size()), 32'h4, "bytes");
      for (int k = 0; k < 4; k++)
      begin
        e = (k < mx) ? memval(st + 32'(k)) : 8'hc3;
        e = m[0] ? rev8(e) : e;
        check(32'(spi_master_model_i.rx_q[k]), 32'(e), "byte");
      end
      check(32'(addr_q.size()), mx, "fetches");
      for (int k = 0; k < addr_q.size() && k < mx; k++)
        check(addr_q[k], st + 32'(k), "fetch address");
      reg_chk(OFF_TX_SENT, mx, "sent");
    end
    $display("test modes done");
  endtask

  task automatic t_ignored();
    int tgt;
    reg_wr(OFF_IGN_FILL, 32'h0000_0096);
    reg_wr(OFF_LINK_FMT, 32'h0000_0000);
    granted_i <= 1'b0;
    addr_q.delete();
    tgt = n_end;
    spi_master_model_i.frame(24, 1'b0, 1'b0);
    repeat (20) @(posedge clk_i);
    for (int k = 0; k < 3; k++)
      check(32'(spi_master_model_i.rx_q[k]), 32'h0000_0096, "ignored");
    check(32'(addr_q.size()), 32'h0, "ignored fetches");
    check(32'(n_end), 32'(tgt), "ignored end pulse");
    reg_chk(OFF_TX_SENT, 32'h0000_0003, "sent kept");
    $display("test ignored done");
  endtask

  // A frame cut off in its second byte counts one byte only.
  task automatic t_abort();
    int tgt;
    int oe0;
    reg_wr(OFF_TX_START, 32'h0000_0040);
    reg_wr(OFF_TX_MAX, 32'h0000_0004);
    granted_i <= 1'b1;
    tgt = n_end + 1;
    oe0 = n_oe;
    spi_master_model_i.frame(12, 1'b0, 1'b0);
    wait_end(tgt);
    // The output is driven for the whole frame, about 108 clocks here.
    check(32'(n_oe - oe0 >= 100), 32'h1, "enable held in frame");
    check(32'(miso_oe_o), 32'h0, "enable after frame");
    check(32'(spi_master_model_i.rx_q[0]), 32'(memval(32'h40)), "abort byte");
    reg_chk(OFF_TX_SENT, 32'h0000_0001, "abort sent");
    $display("test abort done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_regs();
    t_modes();
    t_ignored();
    t_abort();
    final_report();
  end
endmodule // spi_tx_core_tb
